// [verilog/mac_pkg.sv]
`default_nettype none
package mac_pkg;
  // operand and accumulator widths
  localparam int OPERAND_W = 32;
  localparam int ACC_W = 64;
  localparam int GPR_IDX_W = 5;
  // accumulator field positions: upper half, bottom half
  localparam int UPPER_MSB = 63;
  localparam int UPPER_LSB = 32;
  localparam int BOTTOM_MSB = 31;
  localparam int BOTTOM_LSB = 0;
  // reset values
  localparam logic [31:0] UPPER_RESET = 32'h0000_0000;
  localparam logic [31:0] BOTTOM_RESET = 32'h0000_0000;
  localparam logic [31:0] GPR_DATA_RESET = 32'h0000_0000;
  localparam logic [4:0] GPR_IDX_RESET = 5'h00;
  // cycles from a taken operation to its visible result
  localparam int RESULT_LATENCY = 1;

  // operation codes issued by the pipeline
  typedef enum logic [2:0] {
    OP_IDLE = 3'h0,
    OP_MULTIPLY = 3'h1,
    OP_MULTIPLY_ADD = 3'h3,
    OP_MULTIPLY_SUBTRACT = 3'h2,
    OP_PRODUCT_TO_GPR = 3'h6,
    OP_MOVE_FROM_UPPER = 3'h7,
    OP_MOVE_FROM_BOTTOM = 3'h5
  } mac_op_e;
endpackage
`default_nettype wire

// [verilog/mac_multiplier.sv]
`timescale 1ns/1ns
`default_nettype none
module mac_multiplier
  import mac_pkg::*;
(
  input wire logic [31:0] factor_a, // first operand
  input wire logic [31:0] factor_b, // second operand
  input wire logic is_signed, // two's complement operands when high
  output logic [63:0] product // full 64-bit product
);
  logic [65:0] ext_a;
  logic [65:0] ext_b;
  logic signed [65:0] wide;

  ////////////////////////////////////////////////////////////////////////////
  // sign or zero extension lets one signed multiplier serve both forms
  always_comb begin
    ext_a = {{34{is_signed & factor_a[31]}}, factor_a};
    ext_b = {{34{is_signed & factor_b[31]}}, factor_b};
    wide = $signed(ext_a) * $signed(ext_b);
    product = wide[63:0];
  end
endmodule
`default_nettype wire

// [verilog/multiply_accumulate_unit.sv]
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - multiply results land in upper/bottom pair
// - move ops copy selected half to register
// - product_to_gpr_op writes low product directly
// - multiply_add adds product into pair
// - multiply_subtract subtracts product from pair
module multiply_accumulate_unit
  import mac_pkg::*;
(
  input wire logic ref_clk, // core clock, 100 MHz
  input wire logic reset, // synchronous, active high
  input wire logic op_valid, // operation issued this cycle
  input wire logic [2:0] op_code, // mac_op_e encoding
  input wire logic is_signed, // signed multiply when high
  input wire logic [31:0] operand_a, // first source value
  input wire logic [31:0] operand_b, // second source value
  input wire logic [4:0] dest_idx, // destination register index
  output logic gpr_we, // register file write strobe
  output logic [4:0] gpr_idx, // register file write index
  output logic [31:0] gpr_data, // register file write data
  output logic [31:0] upper_product_reg, // accumulator bits 63..32
  output logic [31:0] bottom_product_reg // accumulator bits 31..0
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [63:0] acc;
    logic gpr_we;
    logic [4:0] gpr_idx;
    logic [31:0] gpr_data;
  } mac_state_s;

  mac_state_s state_r;
  mac_state_s state_nxt;
  logic [63:0] product;
  mac_op_e op;

  // full-width product of the two operands
  mac_multiplier u_multiplier (
    .factor_a(operand_a),
    .factor_b(operand_b),
    .is_signed(is_signed),
    .product(product)
  );

  // narrow the pair in one place so slices stay consistent
  // a change of pair layout is then one edit, not five
  function automatic logic [31:0] upper_of(input logic [63:0] v);
    upper_of = v[UPPER_MSB:UPPER_LSB];
  endfunction

  function automatic logic [31:0] bottom_of(input logic [63:0] v);
    bottom_of = v[BOTTOM_MSB:BOTTOM_LSB];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state; unknown codes act as idle so stray issue is harmless
  always_comb begin
    op = mac_op_e'(op_code);
    state_nxt = state_r;
    // strobe cleared first so only decoded writes raise it
    state_nxt.gpr_we = 1'b0;
    if (op_valid) begin
      case (op)
        OP_MULTIPLY: begin
          state_nxt.acc = product;
        end
        OP_MULTIPLY_ADD: begin
          // sums wrap modulo 2^64; the pair has no overflow flag
          state_nxt.acc = state_r.acc + product;
        end
        OP_MULTIPLY_SUBTRACT: begin
          // borrow wraps the same way; no saturation
          state_nxt.acc = state_r.acc - product;
        end
        OP_PRODUCT_TO_GPR: begin
          // pair kept intact so an accumulation in flight survives
          state_nxt.gpr_we = 1'b1;
          state_nxt.gpr_idx = dest_idx;
          state_nxt.gpr_data = bottom_of(product);
        end
        OP_MOVE_FROM_UPPER: begin
          state_nxt.gpr_we = 1'b1;
          state_nxt.gpr_idx = dest_idx;
          state_nxt.gpr_data = upper_of(state_r.acc);
        end
        OP_MOVE_FROM_BOTTOM: begin
          state_nxt.gpr_we = 1'b1;
          state_nxt.gpr_idx = dest_idx;
          state_nxt.gpr_data = bottom_of(state_r.acc);
        end
        default: begin
          state_nxt.gpr_we = 1'b0;
        end
      endcase
    end
  end

  // single register stage for all state
  // synchronous reset: the pair starts from zero after release
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r.acc <= {UPPER_RESET, BOTTOM_RESET};
      state_r.gpr_we <= 1'b0;
      state_r.gpr_idx <= GPR_IDX_RESET;
      state_r.gpr_data <= GPR_DATA_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from flip-flops
  assign gpr_we = state_r.gpr_we;
  assign gpr_idx = state_r.gpr_idx;
  assign gpr_data = state_r.gpr_data;
  assign upper_product_reg = upper_of(state_r.acc);
  assign bottom_product_reg = bottom_of(state_r.acc);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // every issue-triggered property looks one edge after the issue, to match the single
  // register stage; a deeper multiplier would shift them all
  // both halves read as one value, the way the pipeline sees the pair
  logic [63:0] pair_now;
  assign pair_now = {upper_product_reg, bottom_product_reg};

  chk_mult_into_pair: assert property (
    @(posedge ref_clk) disable iff (reset)
    (op_valid && op_code == OP_MULTIPLY) |=>
      (pair_now == $past(product)) && !gpr_we)
    else $error("multiply did not load the pair");

  chk_move_upper: assert property (
    @(posedge ref_clk) disable iff (reset)
    (op_valid && op_code == OP_MOVE_FROM_UPPER) |=>
      gpr_we && gpr_idx == $past(dest_idx) &&
      gpr_data == $past(upper_product_reg))
    else $error("move from upper wrote wrong value");

  chk_move_bottom: assert property (
    @(posedge ref_clk) disable iff (reset)
    (op_valid && op_code == OP_MOVE_FROM_BOTTOM) |=>
      gpr_we && gpr_idx == $past(dest_idx) &&
      gpr_data == $past(bottom_product_reg))
    else $error("move from bottom wrote wrong value");

  chk_direct_product: assert property (
    @(posedge ref_clk) disable iff (reset)
    (op_valid && op_code == OP_PRODUCT_TO_GPR) |=>
      gpr_we && gpr_idx == $past(dest_idx) &&
      gpr_data == $past(product[31:0]) && $stable(pair_now))
    else $error("direct product write wrong");

  chk_acc_add_sum: assert property (
    @(posedge ref_clk) disable iff (reset)
    (op_valid && op_code == OP_MULTIPLY_ADD) |=>
      pair_now == $past(pair_now) + $past(product))
    else $error("multiply add sum wrong");

  chk_acc_sub_diff: assert property (
    @(posedge ref_clk) disable iff (reset)
    (op_valid && op_code == OP_MULTIPLY_SUBTRACT) |=>
      pair_now == $past(pair_now) - $past(product))
    else $error("multiply subtract difference wrong");

  chk_pair_halves: assert property (
    @(posedge ref_clk) disable iff (reset)
    (op_valid && op_code == OP_MULTIPLY) |=>
      upper_product_reg == $past(product[63:32]) &&
      bottom_product_reg == $past(product[31:0]))
    else $error("pair halves misplaced");

  chk_idle_holds: assert property (
    @(posedge ref_clk) disable iff (reset)
    !op_valid |=> !gpr_we && $stable(pair_now))
    else $error("idle cycle changed state");

  chk_write_pulse: assert property (
    @(posedge ref_clk) disable iff (reset)
    gpr_we && !$past(op_valid) |-> 1'b0)
    else $error("write strobe without issue");

  // reset returns every output to its idle value one edge later
  chk_reset_clears: assert property (
    @(posedge ref_clk)
    reset |=> !gpr_we && gpr_idx == GPR_IDX_RESET &&
      gpr_data == GPR_DATA_RESET &&
      pair_now == {UPPER_RESET, BOTTOM_RESET})
    else $error("reset left state behind");

  // codes outside the table, idle included, must leave no trace
  chk_unknown_ignored: assert property (
    @(posedge ref_clk) disable iff (reset)
    (op_valid && !(op_code inside {OP_MULTIPLY, OP_MULTIPLY_ADD,
      OP_MULTIPLY_SUBTRACT, OP_PRODUCT_TO_GPR, OP_MOVE_FROM_UPPER,
      OP_MOVE_FROM_BOTTOM})) |=> !gpr_we && $stable(pair_now))
    else $error("unknown code changed state");

  // a move only reads the pair
  chk_moves_keep_pair: assert property (
    @(posedge ref_clk) disable iff (reset)
    (op_valid && (op_code == OP_MOVE_FROM_UPPER ||
      op_code == OP_MOVE_FROM_BOTTOM)) |=> $stable(pair_now))
    else $error("move disturbed the pair");

  // accumulating forms never touch the register file
  chk_accum_no_write: assert property (
    @(posedge ref_clk) disable iff (reset)
    (op_valid && (op_code == OP_MULTIPLY_ADD ||
      op_code == OP_MULTIPLY_SUBTRACT)) |=> !gpr_we)
    else $error("accumulate wrote the register file");

  // index and data only move with a strobe; a reset edge may clear them
  chk_write_data_holds: assert property (
    @(posedge ref_clk) disable iff (reset)
    !gpr_we && !$past(reset) |-> $stable(gpr_idx) && $stable(gpr_data))
    else $error("write fields changed without strobe");
endmodule
`default_nettype wire

// [tb/gpr_file_model.sv]
`timescale 1ns/1ns
`default_nettype none
module gpr_file_model (
  input wire logic ref_clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic gpr_we, // write strobe from the unit
  input wire logic [4:0] gpr_idx, // write index
  input wire logic [31:0] gpr_data, // write data
  input wire logic [4:0] rd_idx, // read index from the bench
  output logic [31:0] rd_data // read data
);
  logic [31:0] regs_r [32];
  ////////////////////////////////////////////////////////////////////
  // write port; reset clears all so a stale entry cannot pass a check
  always @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) begin
        regs_r[i] <= 32'h0;
      end
    end else if (gpr_we) begin
      regs_r[gpr_idx] <= gpr_data;
    end
  end
  assign rd_data = regs_r[rd_idx];
endmodule
`default_nettype wire

// [tb/multiply_accumulate_unit_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define chk(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module multiply_accumulate_unit_tb
  import mac_pkg::*;
;
  logic ref_clk, reset, op_valid, is_signed, gpr_we;
  logic [2:0] op_code;
  logic [31:0] operand_a, operand_b, gpr_data, upper, bottom, rd_data;
  logic [4:0] dest_idx, gpr_idx, rd_idx;
  logic [63:0] acc;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  multiply_accumulate_unit dut (.ref_clk(ref_clk), .reset(reset),
    .op_valid(op_valid), .op_code(op_code), .is_signed(is_signed),
    .operand_a(operand_a), .operand_b(operand_b), .dest_idx(dest_idx),
    .gpr_we(gpr_we), .gpr_idx(gpr_idx), .gpr_data(gpr_data),
    .upper_product_reg(upper), .bottom_product_reg(bottom));
  gpr_file_model regs_m (.ref_clk(ref_clk), .reset(reset),
    .gpr_we(gpr_we), .gpr_idx(gpr_idx), .gpr_data(gpr_data),
    .rd_idx(rd_idx), .rd_data(rd_data));
  ////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // the run needs under a hundred cycles; this limit only cuts a hang
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      wrap_up();
    end
  end
  // full 64-bit product, sign extension gives the signed form mod 2^64
  function automatic logic [63:0] prod(logic [31:0] a, b, logic s);
    return s ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0, a} * {32'h0, b};
  endfunction
  // drive one op at an edge; the following edge takes it
  task automatic go(mac_op_e op, logic [31:0] a, b, logic s, logic [4:0] d);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= op;
    operand_a <= a;
    operand_b <= b;
    is_signed <= s;
    dest_idx <= d;
    #1;
  endtask
  task automatic stop();
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task automatic t_mult();
    go(OP_MULTIPLY, 32'hffff_ffff, 32'h0000_0002, 1'b0, 5'h00);
    go(OP_MULTIPLY, 32'hffff_ffff, 32'h0000_0002, 1'b1, 5'h00);
    `chk({upper, bottom}, 64'h0000_0001_ffff_fffe)
    `chk(gpr_we, 1'b0)
    stop();
    `chk({upper, bottom}, 64'hffff_ffff_ffff_fffe)
    $display("t_mult done");
  endtask
  // back to back multiply_add, multiply_subtract, move: each sees the last
  task automatic t_accum();
    acc = 64'hffff_ffff_ffff_fffe;
    go(OP_MULTIPLY_ADD, 32'h8000_0000, 32'h8000_0000, 1'b1, 5'h00);
    go(OP_MULTIPLY_SUBTRACT, 32'hffff_ffff, 32'hffff_ffff, 1'b0, 5'h00);
    acc = acc + prod(32'h8000_0000, 32'h8000_0000, 1'b1);
    `chk({upper, bottom}, acc)
    go(OP_MOVE_FROM_UPPER, 32'h0, 32'h0, 1'b0, 5'h03);
    acc = acc - prod(32'hffff_ffff, 32'hffff_ffff, 1'b0);
    `chk({upper, bottom}, acc)
    stop();
    `chk({gpr_we, gpr_idx, gpr_data}, {1'b1, 5'h03, acc[63:32]})
    go(OP_MOVE_FROM_BOTTOM, 32'h0, 32'h0, 1'b0, 5'h1f);
    `chk(gpr_we, 1'b0)
    stop();
    `chk({gpr_we, gpr_idx, gpr_data}, {1'b1, 5'h1f, acc[31:0]})
    rd_idx = 5'h03;
    #1;
    `chk(rd_data, acc[63:32])
    $display("t_accum done");
  endtask
  // direct write of the low product; pair and unknown code leave no mark
  task automatic t_gpr();
    go(OP_PRODUCT_TO_GPR, 32'h1234_5678, 32'h0000_0010, 1'b0, 5'h05);
    go(mac_op_e'(3'h4), 32'hffff_ffff, 32'hffff_ffff, 1'b1, 5'h06);
    `chk({gpr_we, gpr_idx, gpr_data}, {1'b1, 5'h05, 32'h2345_6780})
    `chk({upper, bottom}, acc)
    stop();
    `chk({gpr_we, upper, bottom}, {1'b0, acc})
    rd_idx = 5'h05;
    #1;
    `chk(rd_data, 32'h2345_6780)
    $display("t_gpr done");
  endtask
  // mid-run reset: fields return to idle, the pair restarts from zero
  task automatic t_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    `chk({gpr_idx, gpr_data}, {GPR_IDX_RESET, GPR_DATA_RESET})
    `chk({upper, bottom}, {UPPER_RESET, BOTTOM_RESET})
    go(OP_MULTIPLY_ADD, 32'h0000_0003, 32'h0000_0005, 1'b0, 5'h00);
    stop();
    acc = {UPPER_RESET, BOTTOM_RESET} + prod(32'h3, 32'h5, 1'b0);
    `chk({upper, bottom}, acc)
    $display("t_reset done");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = 3'h0;
    is_signed = 1'b0;
    operand_a = 32'h0;
    operand_b = 32'h0;
    dest_idx = 5'h00;
    rd_idx = 5'h00;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    t_mult();
    t_accum();
    t_gpr();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
